// [design/scp_params.svh]
// constants of the message path parser: characters, resets, defaults
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
// characters the parser reacts to
`define SCP_CH_NL 8'h0a
`define SCP_CH_TAB 8'h09
`define SCP_CH_SP 8'h20
`define SCP_CH_COLON 8'h3a
`define SCP_CH_SEMI 8'h3b
`define SCP_CH_COMMA 8'h2c
`define SCP_CH_QMARK 8'h3f
`define SCP_CH_STAR 8'h2a
`define SCP_CH_0 8'h30
`define SCP_CH_9 8'h39
`define SCP_CH_UA 8'h41
`define SCP_CH_UZ 8'h5a
`define SCP_CH_LA 8'h61
`define SCP_CH_LZ 8'h7a
`define SCP_CASE_BIT 8'h20
// decimal radix for parameter and response digits
`define SCP_RADIX 16'h000a
// power-on and reset-command values of the settings
`define SCP_FREQ_RST 16'h0000
`define SCP_MULT_RST 16'h0001
`define SCP_LEV_RST 16'h0000
// value taken when the optional multiplier parameter is left out
`define SCP_MULT_DEF 16'h0001
`endif

// [design/scp_pkg.sv]
// types shared by the message path parser modules
package scp_pkg;
  // keywords that the matcher recognises
  typedef enum logic [3:0] {
    KW_NONE, KW_FREQ, KW_CW, KW_MULT, KW_POW, KW_LEV, KW_STAT,
    KW_OUTP, KW_INIT, KW_IMM, KW_RST, KW_OPC, KW_ON, KW_OFF
  } scp_kw_t;
  // positions in the command tree, root first so reset lands there
  typedef enum logic [3:0] {
    P_ROOT, P_NONE, P_FREQ, P_CW, P_MULT, P_MSTAT, P_POW, P_LEV,
    P_PSTAT, P_OUTP, P_OSTAT, P_INIT, P_IMM, P_RST, P_OPC
  } scp_pos_t;
  // character parser states
  typedef enum logic [1:0] {S_HDR, S_PRM, S_SKIP} scp_pst_t;
  // response sender states
  typedef enum logic [1:0] {T_IDLE, T_CONV, T_EMIT, T_EOL} scp_tst_t;
endpackage : scp_pkg

// [design/scp_kw_match.sv]
// keyword matcher: exact short or long form, upper-cased buffer
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_kw_match import scp_pkg::*; #(
  parameter int KW_MAX = 10 // longest keyword held
) (
  input wire logic [KW_MAX*8-1:0] kbuf, // right-justified, zero fill
  output scp_kw_t kw // matched keyword or none
);
  localparam int BW = KW_MAX*8;

  // mixed forms such as FREQU never equal either literal
  always_comb begin
    kw = KW_NONE;
    if (kbuf == BW'("FREQ") || kbuf == BW'("FREQUENCY")) kw = KW_FREQ;
    else if (kbuf == BW'("CW")) kw = KW_CW;
    else if (kbuf == BW'("MULT") || kbuf == BW'("MULTIPLIER"))
      kw = KW_MULT;
    else if (kbuf == BW'("POW") || kbuf == BW'("POWER")) kw = KW_POW;
    else if (kbuf == BW'("LEV") || kbuf == BW'("LEVEL")) kw = KW_LEV;
    else if (kbuf == BW'("STAT") || kbuf == BW'("STATE")) kw = KW_STAT;
    else if (kbuf == BW'("OUTP") || kbuf == BW'("OUTPUT")) kw = KW_OUTP;
    else if (kbuf == BW'("INIT") || kbuf == BW'("INITIATE"))
      kw = KW_INIT;
    else if (kbuf == BW'("IMM") || kbuf == BW'("IMMEDIATE")) kw = KW_IMM;
    else if (kbuf == BW'("*RST")) kw = KW_RST;
    else if (kbuf == BW'("*OPC")) kw = KW_OPC;
    else if (kbuf == BW'("ON")) kw = KW_ON;
    else if (kbuf == BW'("OFF")) kw = KW_OFF;
  end
endmodule : scp_kw_match

// [design/scp_resp_tx.sv]
// response sender: unsigned decimal digits, then newline with eoi
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_resp_tx import scp_pkg::*; #(
  parameter int VW = 16, // value width
  parameter int ND = 5 // decimal digits of a full-scale value
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic load, // start a response
  input wire logic [VW-1:0] value, // value to send
  input wire logic tx_ready, // sink takes the byte
  output logic tx_valid, // byte offered
  output logic [7:0] tx_data, // byte
  output logic tx_eoi, // last byte of the message
  output logic busy // response in progress
);
  localparam int IW = (ND > 1) ? $clog2(ND) : 1;
  typedef struct packed {
    scp_tst_t st; // sender state
    logic [VW-1:0] v; // value left to convert
    logic [ND-1:0][3:0] dig; // digits, least significant first
    logic [IW-1:0] idx; // next digit index
    logic [7:0] data; // byte on offer
  } tx_s_t;
  tx_s_t r; // registered state
  tx_s_t n; // next state
  logic [3:0] d; // low digit of v

  // one digit per cycle by constant division; short, so no hurry
  always_comb begin
    n = r;
    d = 4'(r.v % VW'(`SCP_RADIX));
    case (r.st)
      T_IDLE: begin
        if (load) begin
          n.v = value;
          n.idx = '0;
          n.st = T_CONV;
        end
      end
      T_CONV: begin
        n.dig[r.idx] = d;
        n.v = VW'(r.v / VW'(`SCP_RADIX));
        if (n.v == '0) begin // top digit found
          n.data = 8'(`SCP_CH_0 + {4'h0, d});
          n.st = T_EMIT;
        end else begin
          n.idx = IW'(r.idx + 1'b1);
        end
      end
      T_EMIT: begin
        if (tx_ready) begin
          if (r.idx == '0) begin
            n.data = `SCP_CH_NL; // terminator follows the digits
            n.st = T_EOL;
          end else begin
            n.idx = IW'(r.idx - 1'b1);
            n.data = 8'(`SCP_CH_0 + {4'h0, r.dig[n.idx]});
          end
        end
      end
      T_EOL: begin
        if (tx_ready) n.st = T_IDLE;
      end
      default: n.st = T_IDLE;
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign tx_valid = (r.st == T_EMIT) || (r.st == T_EOL);
  assign tx_data = r.data;
  assign tx_eoi = r.st == T_EOL;
  assign busy = r.st != T_IDLE;
endmodule : scp_resp_tx

// [design/scp_parser.sv]
// program message parser: tree path, dispatch, settings, queries
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_parser import scp_pkg::*; #(
  parameter int KW_MAX = 10, // longest keyword held
  parameter int VW = 16, // setting width
  parameter int ND = 5 // digits of a full-scale response
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic rx_valid, // received byte present
  input wire logic [7:0] rx_data, // received byte
  input wire logic tx_ready, // response sink ready
  output logic tx_valid, // response byte offered
  output logic [7:0] tx_data, // response byte
  output logic tx_eoi, // end-or-identify with last byte
  output logic [VW-1:0] freq_cw, // cw frequency setting
  output logic [VW-1:0] freq_mult, // frequency multiplier
  output logic mult_on, // multiplier state
  output logic [VW-1:0] pow_level, // power level setting
  output logic rf_on, // rf output state
  output logic init_pulse, // trigger event, one cycle
  output logic cmd_error // command error, one cycle
);
  localparam int LW = $clog2(KW_MAX + 1);
  typedef struct packed {
    scp_pst_t st; // character parser state
    logic [KW_MAX*8-1:0] kbuf; // keyword being collected
    logic [LW-1:0] len; // characters in kbuf
    logic ovf; // keyword too long to match
    logic first; // nothing of this command seen yet
    logic common; // command began with an asterisk
    logic query; // header ended in a question mark
    scp_pos_t look; // node where next keyword is sought
    scp_pos_t path; // current path between commands
    scp_pos_t hleaf; // command named by the header
    scp_pos_t hpar; // path the header leaves behind
    logic [VW-1:0] pval; // numeric parameter
    logic has_num; // numeric parameter seen
    logic has_kw; // keyword parameter seen
    logic multi; // comma seen, second parameter
    logic [VW-1:0] freq; // cw frequency
    logic [VW-1:0] mult; // multiplier
    logic [VW-1:0] lev; // power level
    logic mult_on; // multiplier state
    logic rf_on; // rf state
    logic init_p; // trigger pulse
    logic err_p; // error pulse
  } ps_t;
  ps_t r; // registered state
  ps_t n; // next state
  scp_kw_t kw; // matcher answer
  scp_kw_t kwv; // answer, cleared on overflow
  scp_pos_t f_leaf; // command if header ends now
  scp_pos_t f_par; // path if header ends now
  scp_pos_t e_leaf; // command to execute
  scp_pos_t e_par; // path after executing it
  logic e_do; // execute this cycle
  logic bad; // error this cycle
  logic sep; // byte ends a command
  logic term; // byte ends the message
  logic haspar; // any parameter present
  logic bok; // parameter is a valid boolean
  logic bval; // its value
  logic [7:0] uc; // upper-cased byte
  logic tx_load; // start a response
  logic [VW-1:0] tx_val; // value to respond with
  logic tx_busy; // response in progress

  // command separators
  function automatic logic is_sep(input logic [7:0] c);
    return c == `SCP_CH_SEMI || c == `SCP_CH_NL;
  endfunction : is_sep

  // whitespace characters
  function automatic logic is_ws(input logic [7:0] c);
    return c == `SCP_CH_SP || c == `SCP_CH_TAB;
  endfunction : is_ws

  // decimal digit
  function automatic logic is_dig(input logic [7:0] c);
    return c >= `SCP_CH_0 && c <= `SCP_CH_9;
  endfunction : is_dig

  // lower-case letter
  function automatic logic is_low(input logic [7:0] c);
    return c >= `SCP_CH_LA && c <= `SCP_CH_LZ;
  endfunction : is_low

  // any letter
  function automatic logic is_alpha(input logic [7:0] c);
    return is_low(c) || (c >= `SCP_CH_UA && c <= `SCP_CH_UZ);
  endfunction : is_alpha

  // fold case so matching is case free
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return is_low(c) ? (c ^ `SCP_CASE_BIT) : c;
  endfunction : upcase

  // child of a tree node, or none
  function automatic scp_pos_t step(input scp_pos_t p,
                                    input scp_kw_t k);
    scp_pos_t q;
    q = P_NONE;
    case (p)
      P_ROOT: begin
        if (k == KW_FREQ) q = P_FREQ;
        else if (k == KW_POW) q = P_POW;
        else if (k == KW_OUTP) q = P_OUTP;
        else if (k == KW_INIT) q = P_INIT;
      end
      P_FREQ: begin
        if (k == KW_CW) q = P_CW;
        else if (k == KW_MULT) q = P_MULT;
      end
      P_MULT: if (k == KW_STAT) q = P_MSTAT;
      P_POW: begin
        if (k == KW_LEV) q = P_LEV;
        else if (k == KW_STAT) q = P_PSTAT;
      end
      P_OUTP: if (k == KW_STAT) q = P_OSTAT;
      P_INIT: if (k == KW_IMM) q = P_IMM;
      default: q = P_NONE;
    endcase
    return q;
  endfunction : step

  // stand in the implied subcommand of a bare parent
  function automatic scp_pos_t implied(input scp_pos_t p);
    case (p)
      P_FREQ: return P_CW;
      P_POW: return P_LEV;
      P_OUTP: return P_OSTAT;
      P_INIT: return P_IMM;
      default: return p;
    endcase
  endfunction : implied

  // common commands sit outside the tree
  function automatic scp_pos_t common_leaf(input scp_kw_t k);
    if (k == KW_RST) return P_RST;
    if (k == KW_OPC) return P_OPC;
    return P_NONE;
  endfunction : common_leaf

  scp_kw_match #(.KW_MAX(KW_MAX)) u_match (
    .kbuf(r.kbuf),
    .kw(kw)
  );

  scp_resp_tx #(.VW(VW), .ND(ND)) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(tx_load),
    .value(tx_val),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_eoi(tx_eoi),
    .busy(tx_busy)
  );

  // one byte per cycle, no stall toward the sender
  always_comb begin
    n = r;
    n.init_p = 1'b0;
    n.err_p = 1'b0;
    bad = 1'b0;
    e_do = 1'b0;
    e_leaf = P_NONE;
    e_par = r.path;
    tx_load = 1'b0;
    tx_val = '0;
    uc = upcase(rx_data);
    sep = is_sep(rx_data);
    term = rx_data == `SCP_CH_NL;
    kwv = r.ovf ? KW_NONE : kw;
    // common commands keep the path as it is, except *RST, which sends it back to root at the separator
    f_leaf = r.common ? common_leaf(kwv) : implied(step(r.look, kwv));
    f_par = r.common ? r.path : r.look;
    haspar = r.has_num | r.has_kw;
    // ON and 1 mean the same; OFF and 0 likewise
    if (r.has_kw) begin
      bok = kwv == KW_ON || kwv == KW_OFF;
      bval = kwv == KW_ON;
    end else begin
      bok = r.has_num && r.pval[VW-1:1] == '0;
      bval = r.pval[0];
    end
    if (rx_valid) begin
      case (r.st)
        S_HDR: begin
          if (sep) begin
            if (!r.first) begin // empty command does nothing
              e_do = 1'b1;
              e_leaf = f_leaf;
              e_par = f_par;
            end
          end else if (rx_data == `SCP_CH_COLON) begin
            if (r.first) begin
              n.look = P_ROOT;
              n.first = 1'b0;
            end else if (r.len == '0 || r.query || r.common) begin
              bad = 1'b1; // empty level, colon after query or colon in a common command
            end else begin
              n.look = step(r.look, kwv);
              bad = n.look == P_NONE;
              n.kbuf = '0;
              n.len = '0;
              n.ovf = 1'b0;
            end
          end else if (is_ws(rx_data)) begin
            // whitespace closes the header; a split keyword
            // then shows up as a bad parameter
            if (!r.first) begin
              if (r.len == '0) begin
                bad = 1'b1;
              end else begin
                n.hleaf = f_leaf;
                n.hpar = f_par;
                n.st = S_PRM;
                n.kbuf = '0;
                n.len = '0;
                n.ovf = 1'b0;
              end
            end
          end else if (rx_data == `SCP_CH_QMARK) begin
            bad = r.len == '0 || r.query;
            n.query = 1'b1;
          end else if (rx_data == `SCP_CH_STAR || is_alpha(rx_data) ||
                       is_dig(rx_data)) begin
            bad = r.query || (rx_data == `SCP_CH_STAR && !r.first);
            n.common = r.common || rx_data == `SCP_CH_STAR;
            n.first = 1'b0;
            n.kbuf = {r.kbuf[KW_MAX*8-9:0], uc};
            if (r.len == LW'(KW_MAX)) n.ovf = 1'b1;
            else n.len = LW'(r.len + 1'b1);
          end else begin
            bad = 1'b1; // stray character in a header
          end
        end
        S_PRM: begin
          if (sep) begin
            e_do = 1'b1;
            e_leaf = r.hleaf;
            e_par = r.hpar;
          end else if (rx_data == `SCP_CH_COMMA) begin
            n.multi = 1'b1;
          end else if (is_ws(rx_data)) begin
            n.multi = r.multi; // spacing inside parameters
          end else if (is_dig(rx_data)) begin
            bad = r.has_kw;
            n.has_num = 1'b1;
            // wraps at the setting width, no range check
            n.pval = VW'(r.pval * VW'(`SCP_RADIX) +
                         VW'(rx_data - `SCP_CH_0));
          end else if (is_alpha(rx_data)) begin
            bad = r.has_num;
            n.has_kw = 1'b1;
            n.kbuf = {r.kbuf[KW_MAX*8-9:0], uc};
            if (r.len == LW'(KW_MAX)) n.ovf = 1'b1;
            else n.len = LW'(r.len + 1'b1);
          end else begin
            bad = 1'b1;
          end
        end
        S_SKIP: n.st = S_SKIP; // drop bytes until a separator
        default: n.st = S_SKIP;
      endcase
    end
    // execute the finished command before the path moves
    if (e_do) begin
      if (e_leaf == P_NONE || r.multi) begin
        bad = 1'b1;
      end else if (r.query) begin
        // a query while a response drains is refused, not queued
        if (haspar || e_leaf == P_IMM || e_leaf == P_RST || tx_busy) begin
          bad = 1'b1;
        end else begin
          tx_load = 1'b1;
          case (e_leaf)
            P_CW: tx_val = r.freq;
            P_MULT: tx_val = r.mult;
            P_LEV: tx_val = r.lev;
            P_MSTAT: tx_val = {{(VW-1){1'b0}}, r.mult_on};
            P_PSTAT, P_OSTAT: tx_val = {{(VW-1){1'b0}}, r.rf_on};
            default: tx_val = {{(VW-1){1'b0}}, 1'b1}; // done flag
          endcase
        end
      end else begin
        case (e_leaf)
          P_CW: begin
            if (r.has_num) n.freq = r.pval;
            else bad = 1'b1;
          end
          P_LEV: begin
            if (r.has_num) n.lev = r.pval;
            else bad = 1'b1;
          end
          P_MULT: begin
            if (!haspar) n.mult = `SCP_MULT_DEF;
            else if (r.has_num) n.mult = r.pval;
            else bad = 1'b1;
          end
          P_MSTAT: begin
            if (bok) n.mult_on = bval;
            else bad = 1'b1;
          end
          P_PSTAT, P_OSTAT: begin
            if (bok) n.rf_on = bval;
            else bad = 1'b1;
          end
          P_IMM: begin
            if (haspar) bad = 1'b1;
            else n.init_p = 1'b1;
          end
          P_RST: begin
            n.freq = `SCP_FREQ_RST;
            n.mult = `SCP_MULT_RST;
            n.lev = `SCP_LEV_RST;
            n.mult_on = 1'b0;
            n.rf_on = 1'b0;
          end
          default: bad = haspar; // operation complete: no effect
        endcase
      end
    end
    // separator: new command, path per what just ran
    if (rx_valid && sep) begin
      n.st = S_HDR;
      n.first = 1'b1;
      n.common = 1'b0;
      n.query = 1'b0;
      n.multi = 1'b0;
      n.has_num = 1'b0;
      n.has_kw = 1'b0;
      n.pval = '0;
      n.kbuf = '0;
      n.len = '0;
      n.ovf = 1'b0;
      if (term || (e_do && !bad && e_leaf == P_RST)) n.path = P_ROOT;
      else if (e_do && !bad) n.path = e_par;
      n.look = n.path;
    end else if (bad) begin
      n.st = S_SKIP;
    end
    n.err_p = bad;
  end

  // state register; power-on state puts the path at root
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.first <= 1'b1;
      r.mult <= `SCP_MULT_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  assign freq_cw = r.freq;
  assign freq_mult = r.mult;
  assign mult_on = r.mult_on;
  assign pow_level = r.lev;
  assign rf_on = r.rf_on;
  assign init_pulse = r.init_p;
  assign cmd_error = r.err_p;
endmodule : scp_parser

// [bench/scp_parser_assertions.sv]
// port checker of the message path parser
`timescale 1ns/1ps
module scp_parser_chk import scp_pkg::*; #(
  parameter int VW = 16 // setting width
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic rx_valid, // byte present
  input wire logic [7:0] rx_data, // byte in
  input wire logic tx_ready, // sink ready
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_data, // byte out
  input wire logic tx_eoi, // last byte
  input wire logic [VW-1:0] freq_cw, // cw setting
  input wire logic [VW-1:0] freq_mult, // multiplier
  input wire logic mult_on, // multiplier state
  input wire logic [VW-1:0] pow_level, // level
  input wire logic rf_on, // rf state
  input wire logic init_pulse, // trigger event
  input wire logic cmd_error // error pulse
);
  logic take; // byte accepted at this edge
  logic sep; // separator accepted
  logic asked; // reply owed to the controller
  logic qpend; // command so far is a query
  assign take = ce && rx_valid;
  assign sep = take && (rx_data == 8'h3b || rx_data == 8'h0a);
  // a later set wins over the clear at the same edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asked <= 1'b0;
      qpend <= 1'b0;
    end else begin
      if (ce && tx_valid && tx_ready && tx_eoi) asked <= 1'b0;
      if (sep) qpend <= 1'b0;
      if (take && rx_data == 8'h3f) begin
        asked <= 1'b1;
        qpend <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  no_unasked_a: assert property ($rose(tx_valid) |-> asked)
    else $error("response without a query");
  query_ans_a: assert property (sep && qpend |->
    ##[1:8] (tx_valid || cmd_error)) else $error("query unanswered");
  eoi_nl_a: assert property (tx_valid && tx_eoi |-> tx_data == 8'h0a)
    else $error("last byte not newline");
  byte_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_eoi))
    else $error("byte dropped before taken");
  digit_only_a: assert property (tx_valid && !tx_eoi |->
    tx_data inside {[8'h30:8'h39]}) else $error("non digit sent");
  reset_vals_a: assert property ($rose(rst_n) |->
    freq_cw == 16'h0000 && freq_mult == 16'h0001 && !mult_on &&
    pow_level == 16'h0000 && !rf_on && !tx_valid)
    else $error("bad reset values");
  set_at_sep_a: assert property ($past(rst_n) &&
    ($changed(freq_cw) || $changed(pow_level) || $changed(rf_on))
    |-> $past(sep)) else $error("setting moved off a separator");
  init_single_a: assert property (init_pulse |-> $past(sep) ##1
    !init_pulse) else $error("trigger not a single pulse");
  cover property (init_pulse);
  cover property (cmd_error);
  cover property (tx_valid && tx_eoi && tx_ready);
endmodule : scp_parser_chk

// [bench/scp_ctl_model.sv]
// remote controller model: sends messages, takes responses
`timescale 1ns/1ps
module scp_ctl_model (
  input wire logic clk, // system clock
  output logic rx_valid, // byte to the parser
  output logic [7:0] rx_data, // byte
  output logic tx_ready, // we take response bytes
  input wire logic tx_valid, // response byte offered
  input wire logic [7:0] tx_data, // response byte
  input wire logic tx_eoi // last response byte
);
  logic [7:0] rq[$]; // response bytes taken
  logic got_eoi; // whole response taken
  logic slow; // lazy listener mode
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
    got_eoi = 1'b0;
  end
  // ready toggles when slow, so bytes must wait
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  // a byte is ours only at an edge with ready high
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rq.push_back(tx_data);
      if (tx_eoi) got_eoi <= 1'b1;
    end
  end
  // one byte a cycle, never waits on a response
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
    end
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // idle line shows no stale byte
  endtask : send
endmodule : scp_ctl_model

// [bench/test_scpi_message_path_parser.sv]
// testbench of the message path parser
`timescale 1ns/1ps
module test_scpi_message_path_parser;
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, low
  logic ce = 1'b1; // enable, dropped in one scenario
  logic rx_valid, tx_ready, tx_valid, tx_eoi; // handshakes
  logic [7:0] rx_data, tx_data; // byte lanes
  logic [15:0] freq_cw, freq_mult, pow_level; // settings
  logic mult_on, rf_on, init_pulse, cmd_error; // flags
  int failures = 0; // mismatches
  int n_compared = 0; // comparisons
  int n_err = 0; // error pulses seen
  int n_init = 0; // trigger pulses seen
  always #5 clk = ~clk;
  scp_parser uut (.clk, .rst_n, .ce, .rx_valid, .rx_data, .tx_ready,
    .tx_valid, .tx_data, .tx_eoi, .freq_cw, .freq_mult, .mult_on,
    .pow_level, .rf_on, .init_pulse, .cmd_error);
  scp_ctl_model ctl (.clk, .rx_valid, .rx_data, .tx_ready, .tx_valid,
    .tx_data, .tx_eoi);
  // pulse tally, pulses last only one cycle
  always @(posedge clk) begin
    if (cmd_error === 1'b1) n_err++;
    if (init_pulse === 1'b1) n_init++;
  end
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // settings land one edge after the separator
  task automatic cmd(input string s);
    ctl.send(s);
    repeat (3) @(negedge clk);
  endtask : cmd
  // a rejected message gives exactly one error
  task automatic bad(input string s);
    int e;
    e = n_err;
    cmd(s);
    check(16'(n_err - e), 16'h0001);
  endtask : bad
  // query and compare the reply, newline added
  task automatic ask(input string s, input string r, input logic lazy);
    int n;
    ctl.rq.delete();
    ctl.got_eoi = 1'b0;
    ctl.slow = lazy;
    ctl.send(s);
    n = 0;
    while (ctl.got_eoi !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      failures++;
      wrap_up();
    end
    r = {r, "\n"};
    check(16'(ctl.rq.size()), 16'(r.len()));
    foreach (ctl.rq[i])
      if (i < r.len()) check(16'(ctl.rq[i]), 16'(r[i]));
    ctl.slow = 1'b0;
    repeat (2) @(negedge clk);
  endtask : ask
  task automatic t_reset();
    check(freq_cw, 16'h0000);
    check(freq_mult, 16'h0001);
    check({15'h0000, rf_on}, 16'h0000);
    check(pow_level, 16'h0000);
    ask("FREQ:MULT?\n", "1", 1'b0);
  endtask : t_reset
  task automatic t_bool();
    cmd("POW:STAT ON\n");
    check({15'h0000, rf_on}, 16'h0001);
    ask("POW:STAT?\n", "1", 1'b1);
    cmd("pow:stat 0\n");
    check({15'h0000, rf_on}, 16'h0000);
    cmd("OUTP:STAT 1\n");
    ask("OUTP?\n", "1", 1'b0);
  endtask : t_bool
  task automatic t_path();
    cmd("FREQ:CW 5;MULT 2\n");
    check(freq_cw, 16'h0005);
    check(freq_mult, 16'h0002);
    bad("FREQ 7;MULT 3\n");
    check(freq_cw, 16'h0007);
    cmd("FREQ:MULT 4;MULT:STAT ON;:FREQ:CW 9\n");
    check({15'h0000, mult_on}, 16'h0001);
    check(freq_cw, 16'h0009);
    cmd("FREQ:MULT\n");
    check(freq_mult, 16'h0001);
    bad("FREQ:MULT 6\nMULT 8\n");
    check(freq_mult, 16'h0006);
  endtask : t_path
  task automatic t_query();
    cmd("POW 123\n");
    ask("POW:LEV?\n", "123", 1'b1);
    cmd("FREQ:CW 65535\n");
    ask("FREQ?\n", "65535", 1'b0);
    ask("*OPC?\n", "1", 1'b0);
    ask("FREQ:CW 0;CW?\n", "0", 1'b1);
  endtask : t_query
  task automatic t_common();
    cmd("FREQ:MULT 5;*OPC;MULT:STAT OFF\n");
    check(freq_mult, 16'h0005);
    check({15'h0000, mult_on}, 16'h0000);
    bad("POW:LEV 9;*RST;LEV 4\n");
    check(pow_level, 16'h0000);
    check(freq_mult, 16'h0001);
  endtask : t_common
  task automatic t_errors();
    int i;
    ctl.rq.delete();
    bad("FREQ uency:CW 3\n");
    bad("FREQU:CW 3\n");
    bad("FREQ:CW 1,2\n");
    bad("INIT:IMM?\n");
    bad("FOO 1\n");
    check(freq_cw, 16'h0000);
    check(16'(ctl.rq.size()), 16'h0000);
    cmd("FREQUENCY:CW\t12\n");
    check(freq_cw, 16'h000c);
    i = n_init;
    cmd("INIT;:INIT:IMM\n");
    check(16'(n_init - i), 16'h0002);
  endtask : t_errors
  // a setting while a reply drains, a frozen enable, a mid-run reset
  task automatic t_hold();
    ctl.rq.delete();
    ctl.slow = 1'b1;
    ctl.send("FREQ?\n");
    cmd("POW 77\n");
    ctl.slow = 1'b0;
    check(pow_level, 16'h004d);
    check(16'(ctl.rq.size()), 16'h0003);
    ctl.rq.delete();
    // bytes offered while frozen must leave no trace
    ce = 1'b0;
    cmd("FREQ:CW?\n");
    ce = 1'b1;
    repeat (8) @(negedge clk);
    check(16'(ctl.rq.size()), 16'h0000);
    // leave the path below root, then reset in mid message
    ctl.send("FREQ:CW 3;");
    check(freq_cw, 16'h0003);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(freq_cw, 16'h0000);
    bad("CW 5\n");
    check(freq_cw, 16'h0000);
  endtask : t_hold
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_bool();
    t_path();
    t_query();
    t_common();
    t_errors();
    t_hold();
    wrap_up();
  end
endmodule : test_scpi_message_path_parser
bind scp_parser scp_parser_chk #(.VW(VW)) chk (.clk, .rst_n, .ce,
  .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data, .tx_eoi, .freq_cw,
  .freq_mult, .mult_on, .pow_level, .rf_on, .init_pulse, .cmd_error);
